// [pkg/bhpc_pkg.sv]
// Package of constants and types for the buck hiccup and phase control block
package bhpc_pkg;

    // Wishbone register offsets (byte addresses)
    localparam logic [7:0] BHPC_REG_CTRL    = 8'h00;
    localparam logic [7:0] BHPC_REG_STATUS  = 8'h04;
    localparam logic [7:0] BHPC_REG_CONFIG  = 8'h08;
    localparam logic [7:0] BHPC_REG_HICCUP  = 8'h0C;
    localparam logic [7:0] BHPC_REG_OFFCNT  = 8'h10;
    localparam logic [7:0] BHPC_REG_DEADT   = 8'h14;

    // Control register fields
    localparam int BHPC_CTRL_ENABLE_BIT  = 0;
    localparam int BHPC_CTRL_SECEN_BIT   = 1;
    localparam int BHPC_CTRL_FORCED_PWM_MODE_BIT    = 2;
    localparam logic [2:0] BHPC_CTRL_RESET = 3'h3;

    // Counter figures
    localparam int BHPC_OVL_CYCLES       = 512;
    localparam int BHPC_OFF_CYCLES       = 16384;
    localparam int BHPC_CLEAN_CYCLES     = 4;
    localparam int BHPC_OC_EVENTS        = 16;
    localparam int BHPC_SYNC_LOCK_CYCLES = 2;

    // Soft start of 3 ms at 25 MHz
    localparam int BHPC_CLK_HZ           = 25000000;
    localparam int BHPC_SS_TIME_US       = 3000;
    localparam int BHPC_SS_CYCLES        = BHPC_SS_TIME_US * (BHPC_CLK_HZ / 1000000);
    localparam int BHPC_DEADT_RESET      = 2;

    // Configuration select codes
    localparam logic [2:0] BHPC_CFG_P_OFF_SGL = 3'h0;
    localparam logic [2:0] BHPC_CFG_P_ON_SGL  = 3'h1;
    localparam logic [2:0] BHPC_CFG_P_OFF_DUAL = 3'h2;
    localparam logic [2:0] BHPC_CFG_P_ON_DUAL = 3'h3;
    localparam logic [2:0] BHPC_CFG_SECONDARY = 3'h4;

    // Decoded configuration
    typedef struct packed {
        logic secondary;
        logic spread;
        logic dual;
    } bhpc_cfg_t;

    // Gate driver states
    typedef enum logic [3:0] {
        BHPC_GD_OFF  = 4'h1,
        BHPC_GD_HIGH = 4'h2,
        BHPC_GD_DEAD = 4'h4,
        BHPC_GD_LOW  = 4'h8
    } bhpc_gd_t;

    // Hiccup states
    typedef enum logic [3:0] {
        BHPC_HC_SS   = 4'h1,
        BHPC_HC_RUN  = 4'h2,
        BHPC_HC_OFF  = 4'h4,
        BHPC_HC_IDLE = 4'h8
    } bhpc_hc_t;

    // Decode a configuration code into its three settings
    function automatic bhpc_cfg_t bhpc_decode(input logic [2:0] code);
        bhpc_cfg_t c;
        c = '0;
        case (code)
            BHPC_CFG_P_ON_SGL:   c.spread = 1'b1;
            BHPC_CFG_P_OFF_DUAL: c.dual = 1'b1;
            BHPC_CFG_P_ON_DUAL:
            begin
                c.spread = 1'b1;
                c.dual = 1'b1;
            end
            BHPC_CFG_SECONDARY:
            begin
                c.secondary = 1'b1;
                c.dual = 1'b1;
            end
            default: c = '0;
        endcase
        return c;
    endfunction : bhpc_decode

endpackage : bhpc_pkg

// [pkg/bhpc_gate_if.sv]
// Interface between the supervisor and the gate interlock
`timescale 1ns/1ps
`default_nettype none
interface bhpc_gate_if;
    logic       pwm_on;
    logic       gate_en;
    logic       ho_gate_low;
    logic       lo_gate_low;
    logic [7:0] dead_cycles;
    logic       high_side_drive;
    logic       low_side_drive;

    modport ctrl (output pwm_on, output gate_en, output ho_gate_low, output lo_gate_low,
                  output dead_cycles, input high_side_drive, input low_side_drive);
    modport gate (input pwm_on, input gate_en, input ho_gate_low, input lo_gate_low,
                  input dead_cycles, output high_side_drive, output low_side_drive);
endinterface : bhpc_gate_if
`default_nettype wire

// [logic/bhpc_gate_interlock.sv]
// Adaptive dead-time interlock for the two gate drives
`timescale 1ns/1ps
`default_nettype none
module bhpc_gate_interlock
    import bhpc_pkg::*;
(
    // Clocking
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic clk_en,
    // Supervisor side
    bhpc_gate_if.gate gif
);
    bhpc_gd_t   state_q;
    logic [7:0] dly_q;
    logic       ho_q;
    logic       lo_q;

    assign gif.high_side_drive = ho_q;
    assign gif.low_side_drive  = lo_q;

    // Driver sequencing: never both on
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= BHPC_GD_OFF;
            dly_q   <= 8'h00;
            ho_q    <= 1'b0;
            lo_q    <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state_q)
                BHPC_GD_OFF:
                begin
                    ho_q <= 1'b0;
                    lo_q <= 1'b0;
                    if (gif.gate_en && gif.pwm_on && gif.lo_gate_low)
                    begin
                        state_q <= BHPC_GD_HIGH;
                        ho_q    <= 1'b1;
                    end
                end
                BHPC_GD_HIGH:
                begin
                    if (!gif.gate_en || !gif.pwm_on)
                    begin
                        ho_q    <= 1'b0;
                        dly_q   <= gif.dead_cycles;
                        state_q <= BHPC_GD_DEAD;
                    end
                end
                BHPC_GD_DEAD:
                begin
                    if (!gif.gate_en)
                        state_q <= BHPC_GD_OFF;
                    else if (gif.ho_gate_low)
                    begin
                        if (dly_q == 8'h00)
                        begin
                            lo_q    <= 1'b1;
                            state_q <= BHPC_GD_LOW;
                        end
                        else
                            dly_q <= dly_q - 8'h01;
                    end
                end
                BHPC_GD_LOW:
                begin
                    if (!gif.gate_en || gif.pwm_on)
                    begin
                        lo_q    <= 1'b0;
                        state_q <= BHPC_GD_OFF;
                    end
                end
                default: state_q <= BHPC_GD_OFF;
            endcase
        end
    end
endmodule : bhpc_gate_interlock
`default_nettype wire

// [logic/bhpc_top.sv]
// Supervisory logic of a synchronous buck controller: hiccup, config, phase clock
// Notes on behaviour
// - End the high-side pulse at once when sensed current exceeds the limit.
// - Enable soft-start clamp only after sixteen overcurrent events.
// - After overload, keep cycle limiting while counting 512 switching cycles.
// - Clear overload counter after four clean consecutive switching cycles.
// - On expiry, discharge soft start, disable both drives, start off counter.
// - At off-count end, release soft start and restart normally.
// - Hiccup inactive for the whole soft start, and in run while feedback is below 0.4 V.
// - Drop high side, wait for its gate low, then delay before low side.
// - Hold high-side turn-on until low-side gate is low.
// - Latch configuration at bias good; ignore changes until bias fails.
// - Decode five codes into role, spread spectrum and dual phase.
// - Primary with spread spectrum never synchronizes to external clock.
// - Secondary puts its error amplifier output in high impedance.
// - No internal compensation option while dual phase.
// - Dual-phase primary outputs phase clock antiphase to high-side drive.
// - Secondary takes its oscillator from the primary's phase clock.
// - External clock appearing after start-up is locked after two cycles.
// - Primary stops phase clock while pulse skipping; shedding only forced PWM.
// - Re-enabled secondary discharges soft start and runs full soft start.
// - Internal soft-start ramp lasts about three milliseconds.
`timescale 1ns/1ps
`default_nettype none
module bhpc_top
    import bhpc_pkg::*;
#(
    parameter int OFF_CYCLES = BHPC_OFF_CYCLES,
    parameter int SS_CYCLES  = BHPC_SS_CYCLES,
    parameter int OSC_DIV    = 64
)(
    // Clocking
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Analog comparators and pins
    input  wire logic        bias_good,
    input  wire logic [2:0]  config_select,
    input  wire logic        current_limit_trip,
    input  wire logic        feedback_above_0v4,
    input  wire logic        ho_gate_low,
    input  wire logic        lo_gate_low,
    input  wire logic        mode_sync_input,
    input  wire logic        ext_clock_present,
    input  wire logic        phase_clock_in,
    input  wire logic        pulse_skip_active,
    input  wire logic        pwm_compare,
    // Drives and outputs
    output logic             high_side_drive,
    output logic             low_side_drive,
    output logic             power_good_out,
    output logic             ss_discharge,
    output logic             ss_clamp_en,
    output logic             err_amp_hiz,
    output logic             int_comp_allowed,
    output logic [15:0]      ss_level
);
    // Refuse sizes that the counters cannot hold
    if (OFF_CYCLES < 2 || OFF_CYCLES > 65535 || SS_CYCLES < 1 || SS_CYCLES > 131072
        || OSC_DIV < 4 || OSC_DIV > 512)
    begin : g_bad_param
        $error("bhpc_top: parameter out of range");
    end

    localparam logic [15:0] OFF_LAST = 16'(OFF_CYCLES); // Full off time in cycles
    localparam logic [16:0] SS_LAST  = 17'(SS_CYCLES - 1);
    localparam logic [7:0]  OSC_HALF = 8'(OSC_DIV / 2 - 1);

    // Registers and state
    logic [2:0]  ctrl_q;
    bhpc_cfg_t   cfg_q;
    logic        cfg_valid_q;
    bhpc_hc_t    hc_q;
    logic [9:0]  ovl_cnt_q;
    logic [15:0] off_cnt_q;
    logic [2:0]  clean_q;
    logic [4:0]  oc_events_q;
    logic        cyc_trip_q;
    logic        ovl_q;
    logic [16:0] ss_cnt_q;
    logic [7:0]  osc_cnt_q;
    logic        osc_q;
    logic        osc_d1_q;
    logic        pin_d1_q;
    logic [1:0]  sync_lock_q;
    logic        ext_d1_q;
    logic        sec_en_d1_q;
    logic        pwm_latch_q;
    logic [7:0]  deadt_q;

    // Cycle strobe from the active oscillator
    logic cyc_start;
    logic use_ext;
    logic sec_en;
    logic sec_rise;
    assign cyc_start = osc_q && !osc_d1_q;
    assign use_ext   = cfg_valid_q && !cfg_q.secondary && !cfg_q.spread && ext_clock_present
                       && (sync_lock_q == 2'(BHPC_SYNC_LOCK_CYCLES));
    assign sec_en    = ctrl_q[BHPC_CTRL_ENABLE_BIT]
                       && (!cfg_q.secondary || ctrl_q[BHPC_CTRL_SECEN_BIT]);
    assign sec_rise  = sec_en && !sec_en_d1_q;

    // Gate interlock connection
    bhpc_gate_if gif ();
    assign gif.pwm_on      = pwm_latch_q;
    assign gif.gate_en     = sec_en && (hc_q != BHPC_HC_OFF) && (hc_q != BHPC_HC_IDLE);
    assign gif.ho_gate_low = ho_gate_low;
    assign gif.lo_gate_low = lo_gate_low;
    assign gif.dead_cycles = deadt_q;

    bhpc_gate_interlock u_gate (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .gif      (gif)
    );

    // Configuration latch at bias good, released on bias failure
    always_ff @(posedge core_clk)
    begin
        if (srst || !bias_good)
        begin
            cfg_q       <= '0;
            cfg_valid_q <= 1'b0;
        end
        else if (clk_en && !cfg_valid_q)
        begin
            cfg_q       <= bhpc_decode(config_select);
            cfg_valid_q <= 1'b1;
        end
    end

    // Oscillator: own divider, external sync, or primary phase clock
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            osc_cnt_q   <= 8'h00;
            osc_q       <= 1'b0;
            osc_d1_q    <= 1'b0;
            pin_d1_q    <= 1'b0;
            ext_d1_q    <= 1'b0;
            sync_lock_q <= 2'h0;
        end
        else if (clk_en)
        begin
            osc_d1_q <= osc_q;
            pin_d1_q <= cfg_q.secondary ? phase_clock_in : mode_sync_input;
            ext_d1_q <= ext_clock_present;
            if (!ext_clock_present)
                sync_lock_q <= 2'h0;
            else if (ext_d1_q && mode_sync_input && !pin_d1_q
                     && sync_lock_q != 2'(BHPC_SYNC_LOCK_CYCLES))
                sync_lock_q <= sync_lock_q + 2'h1;
            if (cfg_q.secondary || use_ext)
                osc_q <= pin_d1_q;
            else if (osc_cnt_q == OSC_HALF)
            begin
                osc_cnt_q <= 8'h00;
                osc_q     <= !osc_q;
            end
            else
                osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end

    // PWM latch: set at cycle start, cut by current limit or compare
    always_ff @(posedge core_clk)
    begin
        if (srst)
            pwm_latch_q <= 1'b0;
        else if (clk_en)
        begin
            if (current_limit_trip || pwm_compare)
                pwm_latch_q <= 1'b0;
            else if (cyc_start && !pulse_skip_active)
                pwm_latch_q <= 1'b1;
        end
    end

    // Overcurrent tracking per switching cycle
    always_ff @(posedge core_clk)
    begin
        if (srst || !bias_good)
        begin
            cyc_trip_q  <= 1'b0;
            clean_q     <= 3'h0;
            oc_events_q <= 5'h00;
            ovl_cnt_q   <= 10'h000;
            ovl_q       <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cyc_start)
            begin
                cyc_trip_q <= current_limit_trip;
                if (hc_q != BHPC_HC_RUN || !feedback_above_0v4)
                begin
                    ovl_q     <= 1'b0;
                    ovl_cnt_q <= 10'h000;
                    clean_q   <= 3'h0;
                end
                else if (cyc_trip_q)
                begin
                    clean_q <= 3'h0;
                    ovl_q   <= 1'b1;
                    if (oc_events_q != 5'(BHPC_OC_EVENTS))
                        oc_events_q <= oc_events_q + 5'h01;
                end
                else if (clean_q == 3'(BHPC_CLEAN_CYCLES - 1))
                begin
                    clean_q     <= 3'h0;
                    ovl_q       <= 1'b0;
                    ovl_cnt_q   <= 10'h000;
                    oc_events_q <= 5'h00;
                end
                else
                    clean_q <= clean_q + 3'h1;
                // Count on unless this cycle clears the counter
                if (ovl_q && hc_q == BHPC_HC_RUN && feedback_above_0v4
                    && (cyc_trip_q || clean_q != 3'(BHPC_CLEAN_CYCLES - 1))
                    && ovl_cnt_q != 10'(BHPC_OVL_CYCLES))
                    ovl_cnt_q <= ovl_cnt_q + 10'h001;
            end
            else if (current_limit_trip)
                cyc_trip_q <= 1'b1;
        end
    end

    // Hiccup sequencer and soft start ramp
    always_ff @(posedge core_clk)
    begin
        if (srst || !bias_good)
        begin
            hc_q      <= BHPC_HC_IDLE;
            off_cnt_q <= 16'h0000;
            ss_cnt_q  <= 17'h00000;
        end
        else if (clk_en)
        begin
            case (hc_q)
                BHPC_HC_IDLE:
                begin
                    ss_cnt_q <= 17'h00000;
                    if (sec_en && cfg_valid_q)
                        hc_q <= BHPC_HC_SS;
                end
                BHPC_HC_SS:
                begin
                    if (!sec_en)
                        hc_q <= BHPC_HC_IDLE;
                    else if (ss_cnt_q == SS_LAST)
                        hc_q <= BHPC_HC_RUN;
                    else
                        ss_cnt_q <= ss_cnt_q + 17'h00001;
                end
                BHPC_HC_RUN:
                begin
                    if (!sec_en)
                        hc_q <= BHPC_HC_IDLE;
                    else if (ovl_cnt_q == 10'(BHPC_OVL_CYCLES))
                    begin
                        hc_q      <= BHPC_HC_OFF;
                        off_cnt_q <= 16'h0000;
                        ss_cnt_q  <= 17'h00000;
                    end
                end
                BHPC_HC_OFF:
                begin
                    if (off_cnt_q == OFF_LAST)
                        hc_q <= BHPC_HC_SS;
                    else if (cyc_start)
                        off_cnt_q <= off_cnt_q + 16'h0001;
                end
                default: hc_q <= BHPC_HC_IDLE;
            endcase
            if (sec_rise)
                ss_cnt_q <= 17'h00000;
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            high_side_drive  <= 1'b0;
            low_side_drive   <= 1'b0;
            power_good_out   <= 1'b0;
            ss_discharge     <= 1'b1;
            ss_clamp_en      <= 1'b0;
            err_amp_hiz      <= 1'b0;
            int_comp_allowed <= 1'b0;
            ss_level         <= 16'h0000;
            sec_en_d1_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            sec_en_d1_q      <= sec_en;
            high_side_drive  <= gif.high_side_drive && !current_limit_trip;
            low_side_drive   <= gif.low_side_drive;
            ss_discharge     <= (hc_q == BHPC_HC_OFF) || (hc_q == BHPC_HC_IDLE);
            ss_clamp_en      <= (oc_events_q == 5'(BHPC_OC_EVENTS));
            err_amp_hiz      <= cfg_valid_q && cfg_q.secondary;
            int_comp_allowed <= cfg_valid_q && !cfg_q.dual;
            ss_level         <= ss_cnt_q[16:1];
            if (cfg_valid_q && cfg_q.dual && !cfg_q.secondary)
                power_good_out <= !gif.high_side_drive && !pulse_skip_active;
            else
                power_good_out <= (hc_q == BHPC_HC_RUN);
        end
    end

    // Wishbone slave: one-cycle ack, writes to control and dead time
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q   <= BHPC_CTRL_RESET;
            deadt_q  <= 8'(BHPC_DEADT_RESET);
        end
        else if (clk_en)
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            begin
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == BHPC_REG_CTRL)
                    ctrl_q <= wb_dat_i[2:0];
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == BHPC_REG_DEADT)
                    deadt_q <= wb_dat_i[7:0];
                case (wb_adr_i)
                    BHPC_REG_CTRL:   wb_dat_o <= {29'h0, ctrl_q};
                    BHPC_REG_STATUS: wb_dat_o <= {24'h0, hc_q, 1'b0, ovl_q,
                                                  ss_clamp_en, ss_discharge};
                    BHPC_REG_CONFIG: wb_dat_o <= {27'h0, cfg_valid_q, use_ext, cfg_q};
                    BHPC_REG_HICCUP: wb_dat_o <= {17'h0, oc_events_q, ovl_cnt_q};
                    BHPC_REG_OFFCNT: wb_dat_o <= {16'h0, off_cnt_q};
                    BHPC_REG_DEADT:  wb_dat_o <= {24'h0, deadt_q};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : bhpc_top
`default_nettype wire

// [bench/bhpc_fet_model.sv]
// Power MOSFET gate model: gate voltages lag their drives
`timescale 1ns/1ps
`default_nettype none
module bhpc_fet_model (
    // Clock
    input  wire logic core_clk,
    // Drives in, gate levels out
    input  wire logic high_side_drive,
    input  wire logic low_side_drive,
    output logic      ho_gate_low,
    output logic      lo_gate_low
);
    logic [1:0] ho_q = 2'h0;
    logic [1:0] lo_q = 2'h0;
    // Gates take two clocks to discharge below threshold
    always_ff @(posedge core_clk)
    begin
        ho_q <= {ho_q[0], high_side_drive};
        lo_q <= {lo_q[0], low_side_drive};
    end
    assign ho_gate_low = !(|ho_q) && !high_side_drive;
    assign lo_gate_low = !(|lo_q) && !low_side_drive;
endmodule : bhpc_fet_model
`default_nettype wire

// [bench/bhpc_props.sv]
// Port-level assertions of the buck hiccup and phase control block
`timescale 1ns/1ps
`default_nettype none
module bhpc_props (
    // Clocking and bus
    input wire logic core_clk, srst, clk_en, wb_cyc_i, wb_stb_i, wb_ack_o,
    // Sense and drives
    input wire logic bias_good, current_limit_trip, ho_gate_low, lo_gate_low,
    input wire logic high_side_drive, low_side_drive, ss_discharge,
    input wire logic err_amp_hiz, int_comp_allowed
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Bias held long enough for the latch to have settled
    sequence bias_held;
        bias_good [*4];
    endsequence
    // High side dropped and its gate discharged
    sequence ho_off;
        !high_side_drive && ho_gate_low;
    endsequence
    no_shoot_a: assert property (!(high_side_drive && low_side_drive))
        else $error("both gate drives on");
    lo_wait_a: assert property ($rose(low_side_drive) |-> $past(ho_gate_low))
        else $error("low side on before high gate low");
    lo_seq_a: assert property (ho_off ##1 $rose(low_side_drive) |-> !high_side_drive)
        else $error("high side on with low side");
    ho_wait_a: assert property ($rose(high_side_drive) |-> $past(lo_gate_low))
        else $error("high side on before low gate low");
    trip_end_a: assert property (clk_en && current_limit_trip && high_side_drive
        |=> !high_side_drive)
        else $error("pulse not ended on trip");
    cfg_hold_a: assert property (bias_held |=> $stable(err_amp_hiz) || !bias_good)
        else $error("latched role changed");
    hiz_comp_a: assert property (err_amp_hiz |-> !int_comp_allowed)
        else $error("internal comp with secondary");
    off_drive_a: assert property (ss_discharge |=> ##1 ss_discharge
        |-> !high_side_drive && !low_side_drive)
        else $error("drives on while discharged");
    ack_resp_a: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no bus answer");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
endmodule : bhpc_props
`default_nettype wire

// [bench/bhpc_top_tb.sv]
// Self-checking bench for the buck hiccup and phase control block
`timescale 1ns/1ps
`default_nettype none
module bhpc_top_tb;
    logic core_clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, bg = 1'b0;
    logic trip = 1'b0, fb = 1'b0, pwm = 1'b0, pci = 1'b0, ack, hs, ls, pg, ssd, clamp;
    logic hiz, ica, ho_gl, lo_gl;
    logic msi = 1'b0, psk = 1'b0; // both low: mode pin low for forced PWM, pulse skipping off
    logic [7:0]  adr = 8'h00, rnd = 8'h4E;
    logic [2:0]  cfg = 3'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [15:0] ssl;
    logic [2:0]  ex;
    int          fails = 0, tests_run = 0, n;
    bhpc_top #(.OFF_CYCLES(16), .SS_CYCLES(20), .OSC_DIV(8)) i_dut (
        .core_clk(core_clk), .srst(srst), .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .bias_good(bg), .config_select(cfg), .current_limit_trip(trip),
        .feedback_above_0v4(fb), .ho_gate_low(ho_gl), .lo_gate_low(lo_gl),
        .mode_sync_input(msi), .ext_clock_present(1'b0), .phase_clock_in(pci),
        .pulse_skip_active(psk), .pwm_compare(pwm), .high_side_drive(hs),
        .low_side_drive(ls), .power_good_out(pg), .ss_discharge(ssd), .ss_clamp_en(clamp),
        .err_amp_hiz(hiz), .int_comp_allowed(ica), .ss_level(ssl));
    bhpc_fet_model i_fet (.core_clk(core_clk), .high_side_drive(hs), .low_side_drive(ls),
        .ho_gate_low(ho_gl), .lo_gate_low(lo_gl));
    // Clock of 40 ns period
    initial forever #20 core_clk = !core_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Random pulse ends and phase clock
    always @(posedge core_clk)
    begin
        rnd <= lfsr(rnd);
        pwm <= rnd[0];
        pci <= rnd[3];
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        if (n >= 50)
        begin
            fails++;
            end_sim();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic clocks(input int c);
        repeat (c) @(posedge core_clk);
    endtask : clocks
    // Count clocks until discharge reaches a level
    task automatic wait_ssd(input logic lvl, input int lim);
        n = 0;
        while (ssd !== lvl && n < lim)
        begin
            @(posedge core_clk);
            n++;
        end
        #1;
    endtask : wait_ssd
    initial
    begin
        #3000000;
        fails++;
        end_sim();
    end
    initial
    begin
        clocks(3);
        srst <= 1'b0;
        wb(1'b0, bhpc_pkg::BHPC_REG_CTRL, 32'h0);
        chk_val(rdat & 32'h7, 32'h3);
        wb(1'b0, bhpc_pkg::BHPC_REG_DEADT, 32'h0);
        chk_val(rdat & 32'hFF, 32'h2);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk_val(rdat, 32'h0);
        $display("test registers done");
        // Every code, then a change that must be ignored (code 2 is rewritten with itself)
        for (int c = 4; c >= 0; c--)
        begin
            ex = {c == 4, c == 1 || c == 3, c >= 2};
            bg <= 1'b0;
            cfg <= c[2:0];
            clocks(4);
            bg <= 1'b1;
            clocks(4);
            cfg <= 3'h4 - c[2:0];
            clocks(4);
            wb(1'b0, bhpc_pkg::BHPC_REG_CONFIG, 32'h0);
            chk_val(rdat & 32'h17, {27'h0, 2'h2, ex});
            chk_val({31'h0, hiz}, {31'h0, ex[2]});
            chk_val({31'h0, ica}, {31'h0, !ex[0]});
            if (ex[0] && !ex[2])
            begin
                chk_val({31'h0, pg}, {31'h0, !hs});
                psk <= 1'b1;
                clocks(2);
                chk_val({31'h0, pg}, 32'h0);
                psk <= 1'b0;
            end
        end
        cfg <= 3'h0;
        $display("test config done");
        wait_ssd(1'b0, 2000);
        trip <= 1'b1;
        clocks(4800);
        chk_val({31'h0, ssd}, 32'h0);
        fb <= 1'b1;
        clocks(64);
        chk_val({31'h0, clamp}, 32'h0);
        clocks(96);
        chk_val({31'h0, clamp}, 32'h1);
        trip <= 1'b0;
        clocks(48);
        wb(1'b0, bhpc_pkg::BHPC_REG_HICCUP, 32'h0);
        chk_val(rdat & 32'h3FF, 32'h0);
        $display("test clamp done");
        trip <= 1'b1;
        wait_ssd(1'b1, 6000);
        chk_rng(n, 511 * 8, 514 * 8);
        clocks(2);
        chk_val({30'h0, hs, ls}, 32'h0);
        wait_ssd(1'b0, 1000);
        chk_rng(n, 15 * 8, 18 * 8);
        trip <= 1'b0;
        $display("test hiccup done");
        end_sim();
    end
endmodule : bhpc_top_tb
bind bhpc_top bhpc_props i_props (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bias_good(bias_good),
    .current_limit_trip(current_limit_trip), .ho_gate_low(ho_gate_low),
    .lo_gate_low(lo_gate_low), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .ss_discharge(ss_discharge),
    .err_amp_hiz(err_amp_hiz), .int_comp_allowed(int_comp_allowed));
`default_nettype wire
